// >>> core/dyn_pkg.sv
package dyn_pkg;
    localparam int SMP_W       = 24;
    localparam int COEF_W      = 22;
    localparam int COEF_FRAC   = 20;
    localparam int ADDR_W      = 10;
    localparam int ACC_W       = 49;
    localparam int PWR_W       = 41;
    localparam int PWR_IDX_OFS = 8;
    localparam int LOG_FRAC_W  = 8;
    localparam int LOG_IDX_W   = 6;
    localparam int LOG_W       = LOG_IDX_W + LOG_FRAC_W;
    localparam int TBL_N       = 33;
    localparam int TBL_TOP     = TBL_N - 1;
    localparam int POST_STAGES = 5;
    localparam int LA_MAX      = 100;
    localparam int LA_DEPTH    = LA_MAX + 1;
    localparam int LA_W        = 8;
    localparam int PRAM_WORDS  = 82;

    typedef logic signed [SMP_W-1:0]  sample_t;
    typedef logic signed [COEF_W-1:0] coef_t;
    typedef logic [ADDR_W-1:0]        addr_t;
    typedef logic [7:0]               reg_adr_t;
    typedef enum logic [1:0] {S_IDLE, S_GAIN, S_APPLY} dev_st_t;

    localparam sample_t SMP_MAX = 24'h7f_ffff;
    localparam sample_t SMP_MIN = 24'h80_0000;

    localparam addr_t PRAM_BASE       = 10'h064;
    localparam addr_t ADR_TCONST [2]  = '{10'h064, 10'h069};
    localparam addr_t ADR_HOLD [2]    = '{10'h065, 10'h06a};
    localparam addr_t ADR_DECAY [2]   = '{10'h066, 10'h06b};
    localparam addr_t ADR_LOOKAHEAD   = 10'h067;
    localparam addr_t ADR_POST [2]    = '{10'h068, 10'h0b5};
    localparam addr_t ADR_W_LEFT      = 10'h06c;
    localparam addr_t ADR_W_RIGHT     = 10'h06d;
    localparam addr_t ADR_TBL [2]     = '{10'h06e, 10'h08f};
    localparam addr_t ADR_BQ [5]      = '{10'h0b0, 10'h0b1, 10'h0b2, 10'h0b3, 10'h0b4};

    localparam reg_adr_t REG_PADDR   = 8'h00;
    localparam reg_adr_t REG_PDATA   = 8'h04;
    localparam reg_adr_t REG_IN_L    = 8'h08;
    localparam reg_adr_t REG_IN_R    = 8'h0c;
    localparam reg_adr_t REG_OUT_L   = 8'h10;
    localparam reg_adr_t REG_OUT_R   = 8'h14;
    localparam reg_adr_t REG_OUT_SUB = 8'h18;
    localparam reg_adr_t REG_STATUS  = 8'h1c;
    localparam int ST_NEW        = 0;
    localparam int ST_OVR        = 1;
    localparam int ST_HOLD_SHORT = 2;
    localparam int ST_TC_BAD     = 3;
    localparam int ST_READY      = 4;
endpackage : dyn_pkg

// >>> core/dyn_if.sv
`timescale 1ns/1ps
interface dyn_if;
    import dyn_pkg::*;
    logic    pram_we;
    addr_t   pram_addr;
    coef_t   pram_wdata;
    logic    in_valid;
    sample_t in_left;
    sample_t in_right;
    logic    in_ready;
    logic    out_valid;
    sample_t out_left;
    sample_t out_right;
    sample_t out_sub;

    modport device (input pram_we, pram_addr, pram_wdata, in_valid, in_left, in_right,
                    output in_ready, out_valid, out_left, out_right, out_sub);
    modport host (output pram_we, pram_addr, pram_wdata, in_valid, in_left, in_right,
                  input in_ready, out_valid, out_left, out_right, out_sub);
endinterface : dyn_if

// >>> core/sat_mul.sv
`timescale 1ns/1ps
module sat_mul import dyn_pkg::*; (
    input  sample_t i_x,
    input  coef_t   i_k,
    output sample_t o_y
);
    logic signed [SMP_W+COEF_W-1:0] prod;

    // Gains above unity must clip at full scale, never wrap round.
    always_comb begin
        prod = i_x * i_k;
        if (prod[SMP_W+COEF_W-1 -: 3] == 3'b000 || prod[SMP_W+COEF_W-1 -: 3] == 3'b111) begin
            o_y = prod[SMP_W+COEF_FRAC-1:COEF_FRAC];
        end else if (prod[SMP_W+COEF_W-1]) begin
            o_y = SMP_MIN;
        end else begin
            o_y = SMP_MAX;
        end
    end
endmodule : sat_mul

// >>> core/dyn_comp_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Detector uses time constant, hold, release.
// - Log upper bits index, lower bits interpolate.
// - Gain table: 33 entries, 3 dB each.
// - Main table at locations 110 to 142.
// - Top entry 0 dB, bottom -96 dB.
// - Table entries are signed 2.20 gains.
// - Table gain below 2.0; more via post-gain.
// - Delay audio, not detector, before multiplier.
// - Host sets hold at least look-ahead.
// - Main detector uses (L+R)/2.
// - Post-gain is five cascaded multipliers.
// - Coefficients are 22-bit 2.20 words.
// - Host computes time constant; release negative (device subtracts a positive release).
// - Hold that many samples before release.
// - Host computes release as rate/1.096.
// - Look-ahead counted in samples, max 100.
// - Host sets post-gain to fifth root.
// - Sub uses weighted left/right sum.
// - Sub detector passes through a biquad.
// - Sub path has no look-ahead delay.
// - Look-ahead buffer only in main channels.
module dyn_comp_device import dyn_pkg::*; (
    input  logic  i_ref_clk,
    input  logic  i_reset_n,
    dyn_if.device bus,
    output coef_t o_main_gain,
    output coef_t o_sub_gain
);
    typedef logic [PRAM_WORDS-1:0][COEF_W-1:0] pram_t;

    typedef struct packed {
        dev_st_t                             st;
        logic                                rdy;
        sample_t                             in_l;
        sample_t                             in_r;
        sample_t                             sub_in;
        pram_t                               pram;
        logic [1:0][PWR_W-1:0]               pwr;
        logic [1:0][LOG_W-1:0]               env;
        logic [1:0][COEF_W-1:0]              hold;
        logic [3:0][SMP_W-1:0]               bq;
        logic [LA_DEPTH-1:0][1:0][SMP_W-1:0] dly;
        logic [LA_W-1:0]                     wp;
        sample_t                             dl_l;
        sample_t                             dl_r;
        logic [1:0][COEF_W-1:0]              gain;
        logic                                out_v;
        logic [2:0][SMP_W-1:0]               out;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    sample_t    wl;
    sample_t    wr;
    sample_t    chain [3][POST_STAGES+2];

    function automatic coef_t pget(input pram_t m, input addr_t a);
        return coef_t'(m[a - PRAM_BASE]);
    endfunction : pget

    function automatic sample_t sat_smp(input logic signed [ACC_W-1:0] v);
        if (v > ACC_W'(SMP_MAX)) begin
            return SMP_MAX;
        end
        if (v < ACC_W'(SMP_MIN)) begin
            return SMP_MIN;
        end
        return v[SMP_W-1:0];
    endfunction : sat_smp

    // Power doubles per 3 dB step of amplitude, so the leading one gives the index.
    function automatic logic [LOG_W-1:0] log_of(input logic [PWR_W-1:0] p);
        int              pos;
        logic [PWR_W-1:0] nrm;
        pos = -1;
        for (int b = 0; b < PWR_W; b++) begin
            if (p[b]) begin
                pos = b;
            end
        end
        if (pos < PWR_IDX_OFS) begin
            return '0;
        end
        nrm = p << (PWR_W - 1 - pos);
        return {LOG_IDX_W'(pos - PWR_IDX_OFS), nrm[PWR_W-2 -: LOG_FRAC_W]};
    endfunction : log_of

    sat_mul u_wleft (.i_x(bus.in_left), .i_k(pget(q.pram, ADR_W_LEFT)), .o_y(wl));
    sat_mul u_wright (.i_x(bus.in_right), .i_k(pget(q.pram, ADR_W_RIGHT)), .o_y(wr));

    genvar gc;
    genvar gs;
    for (gc = 0; gc < 3; gc++) begin : g_ch
        assign chain[gc][0] = (gc == 0) ? q.dl_l : (gc == 1) ? q.dl_r : q.sub_in;
        for (gs = 0; gs <= POST_STAGES; gs++) begin : g_st
            coef_t k;
            // Stage 0 is the compressor gain, the rest make up level.
            assign k = (gs == 0) ? coef_t'(q.gain[gc == 2])
                                 : pget(q.pram, ADR_POST[gc == 2]);
            sat_mul u_mul (.i_x(chain[gc][gs]), .i_k(k), .o_y(chain[gc][gs+1]));
        end
    end

    always_comb begin
        logic signed [SMP_W:0]              lr_sum;
        logic signed [ACC_W-1:0]            acc;
        sample_t                            ws;
        sample_t                            bq_y;
        sample_t                            det_in [2];
        logic signed [2*SMP_W-1:0]          sq;
        logic [PWR_W-1:0]                   pw;
        logic signed [PWR_W:0]              diff;
        logic signed [PWR_W+COEF_W:0]       prod;
        logic signed [PWR_W+1:0]            pnew;
        logic [LOG_W-1:0]                   lg;
        logic [COEF_W-1:0]                  gap;
        logic [COEF_W-1:0]                  rel;
        logic [LOG_IDX_W-1:0]               ix;
        coef_t                              e0;
        coef_t                              e1;
        logic signed [COEF_W:0]             step;
        logic signed [COEF_W+LOG_FRAC_W+1:0] ip;
        logic [LA_W-1:0]                    la;
        logic [LA_W-1:0]                    rp;
        lr_sum = '0;
        acc = '0;
        ws = '0;
        bq_y = '0;
        det_in[0] = '0;
        det_in[1] = '0;
        sq = '0;
        pw = '0;
        diff = '0;
        prod = '0;
        pnew = '0;
        lg = '0;
        gap = '0;
        rel = '0;
        ix = '0;
        e0 = '0;
        e1 = '0;
        step = '0;
        ip = '0;
        la = '0;
        rp = '0;
        d = q;
        d.out_v = 1'b0;
        if (bus.pram_we && bus.pram_addr >= PRAM_BASE
            && bus.pram_addr < PRAM_BASE + PRAM_WORDS) begin
            d.pram[bus.pram_addr - PRAM_BASE] = bus.pram_wdata;
        end
        unique case (q.st)
            S_IDLE: begin
                if (bus.in_valid) begin
                    d.in_l = bus.in_left;
                    d.in_r = bus.in_right;
                    lr_sum = {bus.in_left[SMP_W-1], bus.in_left}
                           + {bus.in_right[SMP_W-1], bus.in_right};
                    det_in[0] = lr_sum[SMP_W:1];
                    ws = sat_smp(ACC_W'(wl) + ACC_W'(wr));
                    d.sub_in = ws;
                    acc = ACC_W'(pget(q.pram, ADR_BQ[0]) * ws)
                        + ACC_W'(pget(q.pram, ADR_BQ[1]) * sample_t'(q.bq[0]))
                        + ACC_W'(pget(q.pram, ADR_BQ[2]) * sample_t'(q.bq[1]))
                        - ACC_W'(pget(q.pram, ADR_BQ[3]) * sample_t'(q.bq[2]))
                        - ACC_W'(pget(q.pram, ADR_BQ[4]) * sample_t'(q.bq[3]));
                    bq_y = sat_smp(acc >>> COEF_FRAC);
                    d.bq = {q.bq[2], bq_y, q.bq[0], ws};
                    det_in[1] = bq_y;
                    for (int k = 0; k < 2; k++) begin
                        sq = det_in[k] * det_in[k];
                        pw = sq[2*SMP_W-2 -: PWR_W];
                        diff = $signed({1'b0, pw}) - $signed({1'b0, q.pwr[k]});
                        prod = diff * pget(q.pram, ADR_TCONST[k]);
                        pnew = $signed({2'b00, q.pwr[k]})
                             + (PWR_W+2)'(prod >>> COEF_FRAC);
                        d.pwr[k] = pnew[PWR_W+1] ? '0 : pnew[PWR_W-1:0];
                    end
                    d.rdy = 1'b0;
                    d.st = S_GAIN;
                end
            end
            S_GAIN: begin
                for (int k = 0; k < 2; k++) begin
                    lg = log_of(q.pwr[k]);
                    rel = pget(q.pram, ADR_DECAY[k]);
                    gap = COEF_W'(q.env[k] - lg);
                    if (lg >= q.env[k]) begin
                        d.env[k] = lg;
                        d.hold[k] = pget(q.pram, ADR_HOLD[k]);
                    end else if (q.hold[k] != '0) begin
                        d.hold[k] = q.hold[k] - 1'b1;
                    end else if (gap > rel) begin
                        d.env[k] = q.env[k] - LOG_W'(rel);
                    end else begin
                        d.env[k] = lg;
                    end
                    ix = d.env[k][LOG_W-1 -: LOG_IDX_W];
                    if (ix > LOG_IDX_W'(TBL_TOP)) begin
                        ix = LOG_IDX_W'(TBL_TOP);
                    end
                    e0 = pget(q.pram, ADR_TBL[k] + ADDR_W'(ix));
                    e1 = (ix == LOG_IDX_W'(TBL_TOP)) ? e0
                       : pget(q.pram, ADR_TBL[k] + ADDR_W'(ix) + 1'b1);
                    step = (COEF_W+1)'(e1) - (COEF_W+1)'(e0);
                    ip = step * $signed({1'b0, d.env[k][LOG_FRAC_W-1:0]});
                    // Result lies between two 2.20 entries, so it cannot exceed 2.0.
                    d.gain[k] = e0 + COEF_W'(ip >>> LOG_FRAC_W);
                end
                la = (q.pram[ADR_LOOKAHEAD - PRAM_BASE] > LA_MAX) ? LA_W'(LA_MAX)
                   : q.pram[ADR_LOOKAHEAD - PRAM_BASE][LA_W-1:0];
                rp = (q.wp >= la) ? q.wp - la : q.wp + LA_W'(LA_DEPTH) - la;
                d.dl_l = (la == '0) ? q.in_l : q.dly[rp][0];
                d.dl_r = (la == '0) ? q.in_r : q.dly[rp][1];
                d.dly[q.wp] = {q.in_r, q.in_l};
                d.wp = (q.wp == LA_W'(LA_DEPTH - 1)) ? '0 : q.wp + 1'b1;
                d.st = S_APPLY;
            end
            S_APPLY: begin
                // Gain was computed from this very frame; it lands on this sub frame and on main audio delayed by the look-ahead.
                d.out = {chain[2][POST_STAGES+1], chain[1][POST_STAGES+1],
                         chain[0][POST_STAGES+1]};
                d.out_v = 1'b1;
                d.rdy = 1'b1;
                d.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.in_ready  = q.rdy;
    assign bus.out_valid = q.out_v;
    assign bus.out_left  = q.out[0];
    assign bus.out_right = q.out[1];
    assign bus.out_sub   = q.out[2];
    assign o_main_gain   = q.gain[0];
    assign o_sub_gain    = q.gain[1];
endmodule : dyn_comp_device

// >>> core/dyn_comp_host.sv
`timescale 1ns/1ps
module dyn_comp_host import dyn_pkg::*; (
    input  logic        i_ref_clk,
    input  logic        i_reset_n,
    dyn_if.host         bus,
    input  reg_adr_t    i_addr,
    input  logic [31:0] i_wdata,
    input  logic        i_wr,
    input  logic        i_rd,
    output logic [31:0] o_rdata
);
    typedef struct packed {
        addr_t                  padr;
        logic                   we;
        addr_t                  wadr;
        coef_t                  wdat;
        logic                   iv;
        sample_t                il;
        sample_t                ir;
        logic [2:0][SMP_W-1:0]  out;
        logic                   new_o;
        logic                   ovr;
        logic                   tc_bad;
        logic [COEF_W-1:0]      hold_v;
        logic [COEF_W-1:0]      la_v;
        logic [31:0]            rdata;
    } host_state_t;

    host_state_t q;
    host_state_t d;

    always_comb begin
        logic [31:0] stat;
        stat = '0;
        d = q;
        d.we = 1'b0;
        d.iv = 1'b0;
        d.rdata = '0;
        if (bus.out_valid) begin
            d.out = {bus.out_sub, bus.out_right, bus.out_left};
        end
        // A new sample in the cycle of the status read stays flagged.
        d.new_o = q.new_o | bus.out_valid;
        if (i_wr) begin
            case (i_addr)
                REG_PADDR: d.padr = i_wdata[ADDR_W-1:0];
                REG_PDATA: begin
                    d.we = 1'b1;
                    d.wadr = q.padr;
                    d.wdat = i_wdata[COEF_W-1:0];
                    d.padr = q.padr + 1'b1;
                    if (q.padr == ADR_HOLD[0]) begin
                        d.hold_v = i_wdata[COEF_W-1:0];
                    end
                    if (q.padr == ADR_LOOKAHEAD) begin
                        d.la_v = i_wdata[COEF_W-1:0];
                    end
                    if (q.padr == ADR_TCONST[0] || q.padr == ADR_TCONST[1]) begin
                        d.tc_bad = i_wdata[COEF_W-1] || i_wdata[COEF_W-1:0] == '0;
                    end
                end
                REG_IN_L: d.il = i_wdata[SMP_W-1:0];
                REG_IN_R: begin
                    // The device takes one frame at a time; a push while busy is lost.
                    if (bus.in_ready && !q.iv) begin
                        d.iv = 1'b1;
                        d.ir = i_wdata[SMP_W-1:0];
                    end else begin
                        d.ovr = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        stat[ST_NEW] = q.new_o;
        stat[ST_OVR] = q.ovr;
        stat[ST_HOLD_SHORT] = q.hold_v < q.la_v;
        stat[ST_TC_BAD] = q.tc_bad;
        stat[ST_READY] = bus.in_ready;
        if (i_rd) begin
            case (i_addr)
                REG_PADDR:   d.rdata = 32'(q.padr);
                REG_OUT_L:   d.rdata = 32'(sample_t'(q.out[0]));
                REG_OUT_R:   d.rdata = 32'(sample_t'(q.out[1]));
                REG_OUT_SUB: d.rdata = 32'(sample_t'(q.out[2]));
                REG_STATUS: begin
                    d.rdata = stat;
                    d.new_o = bus.out_valid;
                    d.ovr = 1'b0;
                end
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.pram_we    = q.we;
    assign bus.pram_addr  = q.wadr;
    assign bus.pram_wdata = q.wdat;
    assign bus.in_valid   = q.iv;
    assign bus.in_left    = q.il;
    assign bus.in_right   = q.ir;
    assign o_rdata        = q.rdata;
endmodule : dyn_comp_host

// >>> tb/dyn_comp_assertions.sv
`timescale 1ns/1ps
module dyn_comp_assertions import dyn_pkg::*; (
    input logic    i_ref_clk,
    input logic    i_reset_n,
    input logic    pram_we,
    input addr_t   pram_addr,
    input logic    in_valid,
    input logic    in_ready,
    input logic    out_valid,
    input sample_t out_left,
    input sample_t out_right,
    input sample_t out_sub
);
    // A frame counts as taken only while the device reports idle.
    logic take;
    assign take = in_valid & in_ready;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    chk_answer_three: assert property (take |-> ##3 out_valid)
        else $error("out_valid not three cycles after a taken frame");
    chk_busy_two: assert property (take |=> !in_ready [*2] ##1 in_ready)
        else $error("in_ready not low for exactly two cycles after a take");
    chk_out_cause: assert property (out_valid |-> $past(take, 3))
        else $error("out_valid without a frame taken three cycles before");
    chk_out_hold: assert property (!out_valid |-> $stable({out_left, out_right, out_sub}))
        else $error("output samples changed without out_valid");
    chk_ready_at_out: assert property (out_valid |-> in_ready)
        else $error("in_ready low while out_valid is high");
    chk_push_ready: assert property (in_valid |-> in_ready)
        else $error("in_valid offered while the device is busy");
    chk_push_gap: assert property (in_valid |=> !in_valid [*2])
        else $error("in_valid repeated inside one processing frame");
    // Back to back parameter writes can only come from one burst.
    chk_burst_step: assert property (pram_we && $past(pram_we) |->
        pram_addr == addr_t'($past(pram_addr) + 10'h001))
        else $error("burst parameter address did not step by one");

    cov_take: cover property (take);
    cov_back_to_back: cover property (out_valid ##[4:20] out_valid);
    cov_burst: cover property (pram_we ##1 pram_we);
endmodule : dyn_comp_assertions

// >>> tb/dual_band_dynamics_compressor_tb_top.sv
`timescale 1ns/1ps
module dual_band_dynamics_compressor_tb_top import dyn_pkg::*;;
    logic        i_ref_clk;
    logic        i_reset_n;
    reg_adr_t    reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    coef_t       main_gain;
    coef_t       sub_gain;
    int          fails;
    int          checked;
    logic [31:0] rv;
    sample_t     ol;
    sample_t     os;

    dyn_if bus_if ();
    dyn_comp_device i_dyn_comp_device (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .bus(bus_if), .o_main_gain(main_gain), .o_sub_gain(sub_gain));
    dyn_comp_host i_dyn_comp_host (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .bus(bus_if), .i_addr(reg_addr), .i_wdata(reg_wdata), .i_wr(reg_wr),
        .i_rd(reg_rd), .o_rdata(reg_rdata));
    dyn_comp_assertions i_dyn_comp_assertions (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .pram_we(bus_if.pram_we), .pram_addr(bus_if.pram_addr),
        .in_valid(bus_if.in_valid), .in_ready(bus_if.in_ready),
        .out_valid(bus_if.out_valid), .out_left(bus_if.out_left),
        .out_right(bus_if.out_right), .out_sub(bus_if.out_sub));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic test_done;
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk

    // A gap cycle follows every strobe so no signal is assigned twice in one step.
    task automatic wr(input reg_adr_t a, input logic [31:0] d);
        @(posedge i_ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input reg_adr_t a, output logic [31:0] d);
        @(posedge i_ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic burst(input addr_t a, input int n, input coef_t v);
        wr(REG_PADDR, {22'h00_0000, a});
        // Words go back to back so that the address step of a burst is exercised.
        @(posedge i_ref_clk);
        reg_addr  <= REG_PDATA;
        reg_wdata <= {10'h000, v};
        reg_wr    <= 1'b1;
        repeat (n) @(posedge i_ref_clk);
        reg_wr    <= 1'b0;
    endtask : burst

    task automatic frame(input sample_t l, input sample_t r);
        int n;
        wr(REG_IN_L, {8'h00, l});
        wr(REG_IN_R, {8'h00, r});
        n = 0;
        while (bus_if.out_valid !== 1'b1 && n < 20) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk("frame answer", 32'h0000_0001, {31'h0000_0000, bus_if.out_valid});
        rd(REG_OUT_L, rv);
        ol = rv[23:0];
        rd(REG_OUT_SUB, rv);
        os = rv[23:0];
    endtask : frame

    // Ramp tables make every index give a distinct gain of index times 1/256.
    function automatic coef_t init_val(input int a);
        if (a >= 10 && a < 76) begin
            return coef_t'(((a - 10) % 33) << 12);
        end
        case (a)
            1, 2, 3, 6, 7, 77, 78, 79, 80: return 22'h00_0000;
            8, 9, 76: return 22'h08_0000;
            default: return 22'h10_0000;
        endcase
    endfunction : init_val

    initial begin
        #200_000;
        chk("watchdog", 32'h0000_0000, 32'h0000_0001);
        test_done();
    end

    initial begin
        i_ref_clk = 1'b0;
        i_reset_n = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        fails     = 0;
        checked   = 0;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rd(REG_STATUS, rv);
        chk("status after reset", 32'h0000_0010, rv);
        rd(8'h20, rv);
        chk("unmapped read", 32'h0000_0000, rv);
        wr(REG_PADDR, {22'h00_0000, PRAM_BASE});
        for (int a = 0; a < PRAM_WORDS; a++) begin
            wr(REG_PDATA, {10'h000, init_val(a)});
        end
        rd(REG_PADDR, rv);
        chk("paddr step", 32'h0000_00b6, rv);
        frame(24'h40_0000, 24'h40_0000);
        chk("main gain", 32'h0001_e000, {10'h000, main_gain});
        chk("sub gain", 32'h0001_c000, {10'h000, sub_gain});
        chk("left out", 32'h0007_8000, {8'h00, ol});
        chk("sub out", 32'h0007_0000, {8'h00, os});
        rd(REG_STATUS, rv);
        chk("status new", 32'h0000_0011, rv);
        rd(REG_OUT_R, rv);
        chk("right out", 32'h0007_8000, rv);
        frame(24'h4e_6e20, 24'h4e_6e20);
        chk("main gain interp", 32'h0001_e800, {10'h000, main_gain});
        frame(SMP_MIN, SMP_MIN);
        chk("main gain top", 32'h0002_0000, {10'h000, main_gain});
        chk("left signed", 32'h00f0_0000, {8'h00, ol});
        // Largest table gain with the largest post gain must clip, not wrap.
        burst(ADR_TBL[0], TBL_N, 22'h1f_ffff);
        burst(ADR_POST[0], 1, 22'h1f_ffff);
        frame(24'h40_0000, 24'h40_0000);
        chk("main gain max", 32'h001f_ffff, {10'h000, main_gain});
        chk("left clip high", 32'h007f_ffff, {8'h00, ol});
        frame(SMP_MIN, SMP_MIN);
        chk("left clip low", 32'h0080_0000, {8'h00, ol});
        burst(ADR_TBL[0], TBL_N, 22'h10_0000);
        burst(ADR_POST[0], 1, 22'h18_0000);
        frame(24'h01_0000, 24'h01_0000);
        chk("post cascade", 32'h0007_9800, {8'h00, ol});
        burst(ADR_POST[0], 1, 22'h10_0000);
        burst(ADR_TBL[1], TBL_N, 22'h10_0000);
        burst(ADR_LOOKAHEAD, 1, 22'h00_0078);
        rd(REG_STATUS, rv);
        chk("hold short", 32'h0000_0004, rv & 32'h0000_0004);
        burst(ADR_HOLD[0], 1, 22'h00_0078);
        // A delay request above the ceiling must act as the ceiling.
        for (int k = 0; k < 102; k++) begin
            frame(sample_t'(32'h0010_0000 + (k << 8)), sample_t'(32'h0010_0000 + (k << 8)));
        end
        chk("delayed left", 32'h0010_0100, {8'h00, ol});
        chk("sub undelayed", 32'h0010_6500, {8'h00, os});
        // Ramp tables again, then a peak held one frame and released one step a frame.
        wr(REG_PADDR, {22'h00_0000, PRAM_BASE});
        for (int a = 0; a < PRAM_WORDS; a++) begin
            wr(REG_PDATA, {10'h000, init_val(a)});
        end
        burst(ADR_HOLD[0], 1, 22'h00_0001);
        burst(ADR_DECAY[0], 1, 22'h00_0100);
        frame(SMP_MIN, SMP_MIN);
        frame(24'h40_0000, 24'h40_0000);
        chk("gain in hold", 32'h0002_0000, {10'h000, main_gain});
        frame(24'h40_0000, 24'h40_0000);
        chk("gain release", 32'h0001_f000, {10'h000, main_gain});
        frame(24'h40_0000, 24'h40_0000);
        chk("gain floor", 32'h0001_e000, {10'h000, main_gain});
        wr(REG_IN_L, 32'h0000_1000);
        wr(REG_IN_R, 32'h0000_1000);
        wr(REG_IN_R, 32'h0000_1000);
        repeat (6) @(posedge i_ref_clk);
        rd(REG_STATUS, rv);
        chk("overrun flag", 32'h0000_0002, rv & 32'h0000_0002);
        burst(ADR_TCONST[1], 1, 22'h00_0000);
        rd(REG_STATUS, rv);
        chk("tconst bad", 32'h0000_0008, rv & 32'h0000_0008);
        test_done();
    end
endmodule : dual_band_dynamics_compressor_tb_top
